//--- inc/sfpm_pkg.sv
package sfpm_pkg;
	// ----------------------------------------
	// sensing widths and scaling
	// ----------------------------------------
	localparam int          ADC_W         = 10;
	localparam int          DIV_RATIO     = 10;
	localparam int          OV_PCT        = 120;
	localparam int          UV_PCT        = 65;
	localparam int          OC_PCT        = 120;
	localparam int          PCT_BASE      = 100;
	// ----------------------------------------
	// default threshold codes, adc counts
	// ----------------------------------------
	localparam logic [9:0]  CEIL_CODE     = 10'h0D2;
	localparam logic [9:0]  OFF_CODE      = 10'h01F;
	localparam logic [9:0]  LATCH_CODE    = 10'h00A;
	localparam logic [9:0]  TWARN_CODE    = 10'h064;
	localparam logic [9:0]  TSHUT_CODE    = 10'h06E;
	localparam logic [9:0]  RESTART_CODE  = 10'h032;
	// ----------------------------------------
	// timing, in microseconds, at 25 MHz
	// ----------------------------------------
	localparam int          CLK_MHZ       = 25;
	localparam int          OV_DEB_US     = 10;
	localparam int          UV_DEB_US     = 10;
	localparam int          BLANK_US      = 100;
	localparam int          THERM_DEB_US  = 1000;
	localparam int          RESTART_US    = 2000000;
	localparam int          OV_DEB_CYC    = OV_DEB_US * CLK_MHZ;
	localparam int          UV_DEB_CYC    = UV_DEB_US * CLK_MHZ;
	localparam int          BLANK_CYC     = BLANK_US * CLK_MHZ;
	localparam int          THERM_DEB_CYC = THERM_DEB_US * CLK_MHZ;
	localparam int          RESTART_CYC   = RESTART_US * CLK_MHZ;
	// ----------------------------------------
	// supervisor states
	// ----------------------------------------
	typedef enum logic [2:0] {
		SFPM_RUN   = 3'b001,
		SFPM_FAULT = 3'b010,
		SFPM_WAIT  = 3'b100
	} sfpm_state_t;
endpackage

//--- logic/sfpm_top.sv
// Functional notes
// R1: on any fault except cable-power overcurrent, drop pull-up, open switch, keep watching.
// R2: after fault clears, run restart timer, then re-attach at 5 V as first attach.
// R3: overvoltage fault when output over 120% of request for debounce time.
// R4: voltage comparisons use output supply divided by ten.
// R5: blank overvoltage detection for blanking interval during voltage transitions.
// R6: cap requested voltage at fixed ceiling whatever the contract.
// R7: fixed contract: undervoltage fault below 65% of request beyond debounce time.
// R8: undervoltage fault never causes an alert to the sink.
// R9: programmable contract suppresses the proportional undervoltage check.
// R10: below shutoff latch undervoltage; release only below lower latch-reset level.
// R11: fixed objects: overcurrent fault at 120% of object maximum current.
// R12: after overcurrent, alert at next explicit contract; keep history flag in status.
// R13: programmable contract regulates constant current at requested value.
// R14: alert on every change between constant current and constant voltage; the code alerts on a change only while in SFPM_RUN.
// R15: programmable status carries regulation flag, measured voltage and current.
// R16: thermistor input biased by fixed current, converted by internal converter.
// R17: status replies carry measured external temperature.
// R18: temperature over warning for debounce time sends alert, no shutdown.
// R19: temperature over shutdown for debounce time raises fault, common response.
// R20: after thermal fault, alert at re-established contract reporting prior event.
// R21: cable-power overcurrent: power off cable, abort discovery, 3 A cap, no alert.
// R22: debounce, blanking and restart durations are design parameters.
`timescale 1ns/1ps
`default_nettype none
module sfpm_top #(
	parameter int OV_DEB_CYC    = sfpm_pkg::OV_DEB_CYC,   // [R22]
	parameter int UV_DEB_CYC    = sfpm_pkg::UV_DEB_CYC,
	parameter int BLANK_CYC     = sfpm_pkg::BLANK_CYC,
	parameter int THERM_DEB_CYC = sfpm_pkg::THERM_DEB_CYC,
	parameter int RESTART_CYC   = sfpm_pkg::RESTART_CYC
) (
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	// contract from protocol engine
	input  wire logic        CONTRACT_PPS,
	input  wire logic [9:0]  REQ_VOLT,
	input  wire logic [9:0]  REQ_CURR,
	input  wire logic        EXPLICIT_CONTRACT,
	input  wire logic        VOLT_TRANSITION,
	// converter samples, output already divided by ten
	input  wire logic [9:0]  SENSE_VOLT,
	input  wire logic [9:0]  SENSE_CURR,
	input  wire logic [9:0]  SENSE_TEMP,
	input  wire logic        INT_OVERTEMP,
	input  wire logic        CABLE_POWER_OVERCURRENT_FAULT,
	// power path control
	output logic             CC_PULLUP_EN,
	output logic             VBUS_SWITCH_EN,
	output logic [9:0]       VOLT_TARGET,
	output logic [9:0]       CURR_LIMIT,
	output logic             CONSTANT_CURRENT_REGULATION,
	output logic             THERMISTOR_BIAS_EN,
	output logic             CABLE_POWER_EN,
	output logic             CABLE_DISCOVERY_ABORT,
	output logic             LIMIT_3A,
	// status to protocol engine
	output logic             ALERT_REQ,
	output logic             ALERT_OCP,
	output logic             ALERT_OTP,
	output logic             ALERT_TEMP_WARN,
	output logic             ALERT_MODE_CHANGE,
	output logic             OUTPUT_OVERVOLTAGE_FAULT,
	output logic             OUTPUT_UNDERVOLTAGE_FAULT,
	output logic             OUTPUT_OVERCURRENT_FAULT,
	output logic             EXT_OVERTEMP_FAULT,
	output logic             OCP_HISTORY,
	output logic [9:0]       STATUS_VOLT,
	output logic [9:0]       STATUS_CURR,
	output logic [9:0]       STATUS_TEMP
);
	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	// a zero count would make a debounce or blanking window vanish, and the restart count wrap
	if (RESTART_CYC < 1 || OV_DEB_CYC < 1 || UV_DEB_CYC < 1 || BLANK_CYC < 1 ||
		THERM_DEB_CYC < 1) begin : gen_bad_timing
		$error("timing counts must be at least one cycle");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		sfpm_pkg::sfpm_state_t st;
		logic [31:0] ov_cnt;
		logic [31:0] uv_cnt;
		logic [31:0] blank_cnt;
		logic [31:0] tw_cnt;
		logic [31:0] ts_cnt;
		logic [31:0] rst_cnt;
		logic        ov;
		logic        uv;
		logic        uv_latch;
		logic        oc;
		logic        otp;
		logic        iotp;
		logic        tw;
		logic        cc_mode;
		logic        pend_ocp;
		logic        pend_otp;
		logic        ocp_hist;
		logic        cable_oc;
		logic        alert;
		logic        a_ocp;
		logic        a_otp;
		logic        a_tw;
		logic        a_mode;
		logic [9:0]  v;
		logic [9:0]  i;
		logic [9:0]  t;
	} sfpm_regs_t;

	sfpm_regs_t r;
	sfpm_regs_t next_r;

	// ----------------------------------------
	// thresholds
	// ----------------------------------------
	logic [9:0]  req_cap;
	logic [19:0] ov_lim;
	logic [19:0] uv_lim;
	logic [19:0] oc_lim;
	logic        any_fault;
	logic        cc_now;
	logic        oc_trip;
	logic        otp_trip;
	always_comb begin
		req_cap = (REQ_VOLT > sfpm_pkg::CEIL_CODE) ? sfpm_pkg::CEIL_CODE : REQ_VOLT; // [R6]
		// scaled in whole percent; product kept at 20 bits
		ov_lim = 20'(req_cap) * 20'(sfpm_pkg::OV_PCT);                       // [R3] [R4]
		uv_lim = 20'(req_cap) * 20'(sfpm_pkg::UV_PCT);                       // [R7] [R4]
		oc_lim = 20'(REQ_CURR) * 20'(sfpm_pkg::OC_PCT);                      // [R11]
		// regulation mode: current at the limit under a programmable contract
		cc_now = CONTRACT_PPS && (SENSE_CURR >= REQ_CURR);                  // [R13]
		any_fault = r.ov || r.uv || r.oc || r.otp || r.iotp;
		// trip events feed the flags and the pending alerts alike, so a set beats a clear
		oc_trip   = !CONTRACT_PPS &&
			(20'(SENSE_CURR) * 20'(sfpm_pkg::PCT_BASE) > oc_lim);             // [R11]
		otp_trip  = INT_OVERTEMP ||
			(SENSE_TEMP > sfpm_pkg::TSHUT_CODE && r.ts_cnt >= 32'(THERM_DEB_CYC)); // [R19]
	end

	// ----------------------------------------
	// supervisor
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.alert  = 1'b0;
		next_r.v = SENSE_VOLT;                                               // [R15]
		next_r.i = SENSE_CURR;                                               // [R15]
		next_r.t = SENSE_TEMP;                                               // [R16] [R17]
		// blanking reloads on every cycle that VOLT_TRANSITION is high
		if (VOLT_TRANSITION)
			next_r.blank_cnt = 32'(BLANK_CYC);                               // [R5]
		else if (r.blank_cnt != 32'h0)
			next_r.blank_cnt = r.blank_cnt - 32'h1;
		// overvoltage debounce, detection held off while blanked
		if (20'(SENSE_VOLT) * 20'(sfpm_pkg::PCT_BASE) > ov_lim && r.blank_cnt == 32'h0
			&& !VOLT_TRANSITION) begin                                       // [R5]
			if (r.ov_cnt < 32'(OV_DEB_CYC))
				next_r.ov_cnt = r.ov_cnt + 32'h1;
			else
				next_r.ov = 1'b1;                                            // [R3]
		end else begin
			next_r.ov_cnt = 32'h0;
			if (r.st != sfpm_pkg::SFPM_RUN)
				next_r.ov = 1'b0;
		end
		// proportional undervoltage, fixed contracts only, only while attached
		if (!CONTRACT_PPS && r.st == sfpm_pkg::SFPM_RUN && VBUS_SWITCH_EN &&
			20'(SENSE_VOLT) * 20'(sfpm_pkg::PCT_BASE) < uv_lim) begin        // [R7] [R9]
			if (r.uv_cnt < 32'(UV_DEB_CYC))
				next_r.uv_cnt = r.uv_cnt + 32'h1;
			else
				next_r.uv = 1'b1;
		end else begin
			next_r.uv_cnt = 32'h0;
			if (r.st != sfpm_pkg::SFPM_RUN && !r.uv_latch)
				next_r.uv = 1'b0;
		end
		// shutoff latch, freed only below the latch-reset level
		if (r.st == sfpm_pkg::SFPM_RUN && VBUS_SWITCH_EN && SENSE_VOLT < sfpm_pkg::OFF_CODE) begin
			next_r.uv_latch = 1'b1;                                          // [R10]
			next_r.uv = 1'b1;
		end else if (r.uv_latch && SENSE_VOLT < sfpm_pkg::LATCH_CODE) begin
			next_r.uv_latch = 1'b0;                                          // [R10]
			next_r.uv = 1'b0;
		end
		// overcurrent for fixed objects
		if (oc_trip) begin
			next_r.oc = 1'b1;                                                // [R11]
			next_r.pend_ocp = 1'b1;
			next_r.ocp_hist = 1'b1;                                          // [R12]
		end else if (r.st != sfpm_pkg::SFPM_RUN)
			next_r.oc = 1'b0;
		// thermal warning and shutdown debounce
		if (SENSE_TEMP > sfpm_pkg::TWARN_CODE) begin
			if (r.tw_cnt < 32'(THERM_DEB_CYC))
				next_r.tw_cnt = r.tw_cnt + 32'h1;
			else if (!r.tw) begin
				next_r.tw = 1'b1;
				next_r.alert = 1'b1;                                         // [R18]
				next_r.a_tw = 1'b1;
			end
		end else begin
			next_r.tw_cnt = 32'h0;
			next_r.tw = 1'b0;
		end
		if (SENSE_TEMP > sfpm_pkg::TSHUT_CODE) begin
			if (r.ts_cnt < 32'(THERM_DEB_CYC))
				next_r.ts_cnt = r.ts_cnt + 32'h1;
			else begin
				next_r.otp = 1'b1;                                           // [R19]
				next_r.pend_otp = 1'b1;
			end
		end else begin
			next_r.ts_cnt = 32'h0;
			next_r.otp = 1'b0;
		end
		next_r.iotp = INT_OVERTEMP;
		if (INT_OVERTEMP)
			next_r.pend_otp = 1'b1;
		// mode change alert, both directions
		next_r.cc_mode = cc_now;
		if (cc_now != r.cc_mode && r.st == sfpm_pkg::SFPM_RUN) begin
			next_r.alert  = 1'b1;                                            // [R14]
			next_r.a_mode = 1'b1;
		end
		// cable-power overcurrent cuts cable power, aborts discovery and trims the offer; no fault
		if (CABLE_POWER_OVERCURRENT_FAULT)
			next_r.cable_oc = 1'b1;                                          // [R21]
		unique case (r.st)
			sfpm_pkg::SFPM_RUN: begin
				if (any_fault)
					next_r.st = sfpm_pkg::SFPM_FAULT;                        // [R1]
				else if (EXPLICIT_CONTRACT && (r.pend_ocp || r.pend_otp)) begin
					next_r.alert    = 1'b1;                                  // [R12] [R20]
					next_r.a_ocp    = r.pend_ocp;
					next_r.a_otp    = r.pend_otp;
					// a trip in this very cycle stays pending for the next contract
					next_r.pend_ocp = oc_trip;
					next_r.pend_otp = otp_trip;
				end
			end
			sfpm_pkg::SFPM_FAULT: begin
				if (!any_fault) begin
					next_r.st      = sfpm_pkg::SFPM_WAIT;                    // [R2]
					next_r.rst_cnt = 32'h0;
				end
			end
			sfpm_pkg::SFPM_WAIT: begin
				if (any_fault)
					next_r.st = sfpm_pkg::SFPM_FAULT;
				else if (r.rst_cnt >= 32'(RESTART_CYC - 1)) begin
					next_r.st       = sfpm_pkg::SFPM_RUN;                    // [R2]
					// a cable fault in the restart cycle keeps the cut in place
					next_r.cable_oc = CABLE_POWER_OVERCURRENT_FAULT;
				end else
					next_r.rst_cnt = r.rst_cnt + 32'h1;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			r    <= '0;
			r.st <= sfpm_pkg::SFPM_WAIT;
		end else
			r <= next_r;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// undervoltage never appears in the alert set
	assign ALERT_REQ                   = r.alert;                            // [R8]
	assign ALERT_OCP                   = r.a_ocp;
	assign ALERT_OTP                   = r.a_otp;
	assign ALERT_TEMP_WARN             = r.a_tw;
	assign ALERT_MODE_CHANGE           = r.a_mode;
	assign CC_PULLUP_EN                = (r.st == sfpm_pkg::SFPM_RUN);       // [R1]
	assign VBUS_SWITCH_EN              = (r.st == sfpm_pkg::SFPM_RUN);       // [R1]
	// restart always offers 5 V until the engine reports an explicit contract
	assign VOLT_TARGET = EXPLICIT_CONTRACT ? req_cap : sfpm_pkg::RESTART_CODE; // [R2]
	assign CURR_LIMIT                  = REQ_CURR;                           // [R13]
	assign CONSTANT_CURRENT_REGULATION = r.cc_mode;                          // [R15]
	assign THERMISTOR_BIAS_EN          = RST_N;                              // [R16]
	assign CABLE_POWER_EN              = !r.cable_oc;                        // [R21]
	assign CABLE_DISCOVERY_ABORT       = r.cable_oc;                         // [R21]
	assign LIMIT_3A                    = r.cable_oc;                         // [R21]
	assign OUTPUT_OVERVOLTAGE_FAULT    = r.ov;
	assign OUTPUT_UNDERVOLTAGE_FAULT   = r.uv;
	assign OUTPUT_OVERCURRENT_FAULT    = r.oc;
	assign EXT_OVERTEMP_FAULT          = r.otp;
	assign OCP_HISTORY                 = r.ocp_hist;                         // [R12]
	assign STATUS_VOLT                 = r.v;
	assign STATUS_CURR                 = r.i;
	assign STATUS_TEMP                 = r.t;                                // [R17]
endmodule
`default_nettype wire

//--- sim/sfpm_props.sv
`timescale 1ns/1ps
`default_nettype none
module sfpm_props (
	// clock and reset
	input wire logic       CLOCK,
	input wire logic       RST_N,
	// watched inputs
	input wire logic       CONTRACT_PPS,
	input wire logic [9:0] REQ_CURR,
	input wire logic       EXPLICIT_CONTRACT,
	input wire logic       VOLT_TRANSITION,
	input wire logic [9:0] SENSE_VOLT,
	input wire logic [9:0] SENSE_CURR,
	input wire logic       CABLE_POWER_OVERCURRENT_FAULT,
	// watched outputs
	input wire logic       CC_PULLUP_EN,
	input wire logic       VBUS_SWITCH_EN,
	input wire logic [9:0] VOLT_TARGET,
	input wire logic       CONSTANT_CURRENT_REGULATION,
	input wire logic       CABLE_POWER_EN,
	input wire logic       CABLE_DISCOVERY_ABORT,
	input wire logic       LIMIT_3A,
	input wire logic       ALERT_REQ,
	input wire logic       OUTPUT_OVERVOLTAGE_FAULT,
	input wire logic       OUTPUT_UNDERVOLTAGE_FAULT,
	input wire logic       OUTPUT_OVERCURRENT_FAULT,
	input wire logic       EXT_OVERTEMP_FAULT,
	input wire logic [9:0] STATUS_VOLT
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	fault_drop_a: assert property ((OUTPUT_OVERVOLTAGE_FAULT || OUTPUT_UNDERVOLTAGE_FAULT
		|| OUTPUT_OVERCURRENT_FAULT || EXT_OVERTEMP_FAULT) |-> ##[0:1] !CC_PULLUP_EN)
		else $error("fault left the sink attached");
	switch_pair_a: assert property (CC_PULLUP_EN == VBUS_SWITCH_EN)
		else $error("pull-up and load switch disagree");
	restart_wait_a: assert property ($fell(CC_PULLUP_EN) |=> !CC_PULLUP_EN[*8])
		else $error("re-attach before restart timer");
	restart_volt_a: assert property (!EXPLICIT_CONTRACT |-> VOLT_TARGET == sfpm_pkg::RESTART_CODE)
		else $error("attach target not 5 V");
	ov_blank_a: assert property (VOLT_TRANSITION |=> !$rose(OUTPUT_OVERVOLTAGE_FAULT))
		else $error("overvoltage raised while blanked");
	target_cap_a: assert property (VOLT_TARGET <= sfpm_pkg::CEIL_CODE)
		else $error("target above ceiling");
	cc_mode_a: assert property ($past(RST_N) |-> CONSTANT_CURRENT_REGULATION
		== $past(CONTRACT_PPS && SENSE_CURR >= REQ_CURR))
		else $error("regulation mode wrong");
	status_volt_a: assert property ($past(RST_N) |-> STATUS_VOLT == $past(SENSE_VOLT))
		else $error("status voltage stale");
	cable_cut_a: assert property ($rose(CABLE_POWER_OVERCURRENT_FAULT) |-> ##[1:3]
		(CABLE_DISCOVERY_ABORT && LIMIT_3A && !CABLE_POWER_EN && !ALERT_REQ && CC_PULLUP_EN))
		else $error("cable fault response wrong");
endmodule
`default_nettype wire

//--- sim/sfpm_sink.sv
`timescale 1ns/1ps
`default_nettype none
module sfpm_sink (
	// link to the source
	input  wire logic clock,
	input  wire logic cc_pull,
	output logic      contract
);
	// sink negotiates a few cycles after it sees the pull-up, loses it on detach
	logic [1:0] cnt = 2'h0;
	initial contract = 1'b0;
	always @(posedge clock) begin
		#2;
		if (!cc_pull) begin
			cnt = 2'h0;
			contract = 1'b0;
		end else if (cnt == 2'h3)
			contract = 1'b1;
		else
			cnt = cnt + 2'h1;
	end
endmodule
`default_nettype wire

//--- sim/source_fault_protection_manager_test.sv
`timescale 1ns/1ps
`default_nettype none
module source_fault_protection_manager_test;
	// ----------------------------------------
	// stimulus, outputs and bookkeeping
	// ----------------------------------------
	logic       clk = 0, rst_n = 0, pps = 0, trans = 0, cab = 0, iotp = 0, contract;
	logic [9:0] req_v = 10'h032, req_c = 10'h064, s_v = 10'h032, s_c = 10'h010;
	logic [9:0] s_t = 10'h010;
	logic       cc_en, ccr, cab_en, abort, lim, areq, a_ocp, a_otp, a_warn, a_mode;
	logic       ov, uv, oc, ot, hist, vbus, bias;
	logic [9:0] vt, st_c, st_t, st_v, cur_lim;
	logic [4:0] notes[$];
	logic [3:0] prev = 4'h0;
	int         num_errors = 0, cmp_count = 0, i;
	always #20 clk = ~clk;
	sfpm_sink sink (.clock(clk), .cc_pull(cc_en), .contract(contract));
	sfpm_top #(.OV_DEB_CYC(4), .UV_DEB_CYC(4), .BLANK_CYC(6), .THERM_DEB_CYC(5),
		.RESTART_CYC(10)) dut (.CLOCK(clk), .RST_N(rst_n), .CONTRACT_PPS(pps),
		.REQ_VOLT(req_v), .REQ_CURR(req_c), .EXPLICIT_CONTRACT(contract),
		.VOLT_TRANSITION(trans), .SENSE_VOLT(s_v), .SENSE_CURR(s_c), .SENSE_TEMP(s_t),
		.INT_OVERTEMP(iotp), .CABLE_POWER_OVERCURRENT_FAULT(cab), .CC_PULLUP_EN(cc_en),
		.VBUS_SWITCH_EN(vbus), .VOLT_TARGET(vt), .CURR_LIMIT(cur_lim),
		.CONSTANT_CURRENT_REGULATION(ccr),
		.THERMISTOR_BIAS_EN(bias), .CABLE_POWER_EN(cab_en), .CABLE_DISCOVERY_ABORT(abort),
		.LIMIT_3A(lim), .ALERT_REQ(areq), .ALERT_OCP(a_ocp), .ALERT_OTP(a_otp),
		.ALERT_TEMP_WARN(a_warn), .ALERT_MODE_CHANGE(a_mode), .OUTPUT_OVERVOLTAGE_FAULT(ov),
		.OUTPUT_UNDERVOLTAGE_FAULT(uv), .OUTPUT_OVERCURRENT_FAULT(oc),
		.EXT_OVERTEMP_FAULT(ot), .OCP_HISTORY(hist), .STATUS_VOLT(st_v), .STATUS_CURR(st_c),
		.STATUS_TEMP(st_t));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// bounded wait for re-attach with a contract in place
	task automatic wait_up();
		for (i = 0; i < 80 && !(cc_en && contract); i++)
			step(1);
		if (i == 80) begin
			num_errors++;
			complete_run();
		end
	endtask
	// alert pulses and new faults are results; each must match the oldest note
	always @(negedge clk) begin
		if (rst_n && (areq || ({ov, uv, oc, ot} != 4'h0 && prev == 4'h0))) begin
			if (notes.size() == 0)
				check({5'h00, areq, ov, uv, oc, ot}, 10'h3FF);
			else
				check({5'h00, areq, ov, uv, oc, ot}, {5'h00, notes.pop_front()});
		end
		prev = {ov, uv, oc, ot};
	end
	initial begin
		void'($urandom(87553));
		step(2);
		rst_n = 1;
		wait_up();
		check({8'h00, bias, vbus}, 10'h003);
		for (int k = 0; k < 20; k++) begin
			s_v = 10'h021 + 10'($urandom % 28);
			step(1);
		end
		s_v = 10'h03C;
		step(12);
		s_v = 10'h03D;
		step(3);
		s_v = 10'h032;
		step(3);
		trans = 1;
		s_v = 10'h03D;
		step(1);
		trans = 0;
		step(4);
		s_v = 10'h032;
		req_v = 10'h3FF;
		step(1);
		check(vt, sfpm_pkg::CEIL_CODE);
		req_v = 10'h032;
		notes.push_back(5'h08);
		s_v = 10'h03D;
		step(12);
		check({7'h00, ov, cc_en, vbus}, 10'h004);
		s_v = 10'h032;
		wait_up();
		notes.push_back(5'h04);
		s_v = 10'h020;
		step(10);
		s_v = 10'h032;
		wait_up();
		pps = 1;
		s_v = 10'h020;
		step(10);
		notes.push_back(5'h10);
		s_c = 10'h064;
		step(4);
		check({9'h000, ccr}, 10'h001);
		s_c = 10'h07A;
		step(8);
		notes.push_back(5'h10);
		s_c = 10'h010;
		step(4);
		check({8'h00, a_mode, ccr}, 10'h002);
		check(st_c, 10'h010);
		check(st_v, s_v);
		check(cur_lim, req_c);
		notes.push_back(5'h04);
		s_v = 10'h01E;
		step(8);
		s_v = 10'h014;
		step(20);
		check({8'h00, uv, cc_en}, 10'h002);
		s_v = 10'h009;
		step(2);
		s_v = 10'h032;
		pps = 0;
		wait_up();
		s_c = 10'h077;
		step(10);
		notes.push_back(5'h02);
		s_c = 10'h07A;
		step(10);
		s_c = 10'h010;
		notes.push_back(5'h10);
		wait_up();
		step(4);
		check({8'h00, a_ocp, hist}, 10'h003);
		cab = 1;
		step(1);
		cab = 0;
		step(3);
		check({7'h00, cab_en, abort, lim}, 10'h003);
		notes.push_back(5'h10);
		s_t = sfpm_pkg::TWARN_CODE + 10'h001;
		step(10);
		check({8'h00, a_warn, cc_en}, 10'h003);
		check(st_t, s_t);
		notes.push_back(5'h01);
		s_t = sfpm_pkg::TSHUT_CODE + 10'h001;
		step(10);
		check({9'h000, cc_en}, 10'h000);
		s_t = 10'h010;
		notes.push_back(5'h10);
		wait_up();
		step(4);
		check({9'h000, a_otp}, 10'h001);
		notes.push_back(5'h10);
		iotp = 1;
		step(3);
		check({8'h00, cc_en, vbus}, 10'h000);
		iotp = 0;
		wait_up();
		step(4);
		check(10'(notes.size()), 10'h000);
		complete_run();
	end
endmodule
bind sfpm_top sfpm_props chk (.CLOCK(CLOCK), .RST_N(RST_N), .CONTRACT_PPS(CONTRACT_PPS),
	.REQ_CURR(REQ_CURR), .EXPLICIT_CONTRACT(EXPLICIT_CONTRACT),
	.VOLT_TRANSITION(VOLT_TRANSITION), .SENSE_VOLT(SENSE_VOLT), .SENSE_CURR(SENSE_CURR),
	.CABLE_POWER_OVERCURRENT_FAULT(CABLE_POWER_OVERCURRENT_FAULT),
	.CC_PULLUP_EN(CC_PULLUP_EN), .VBUS_SWITCH_EN(VBUS_SWITCH_EN), .VOLT_TARGET(VOLT_TARGET),
	.CONSTANT_CURRENT_REGULATION(CONSTANT_CURRENT_REGULATION),
	.CABLE_POWER_EN(CABLE_POWER_EN), .CABLE_DISCOVERY_ABORT(CABLE_DISCOVERY_ABORT),
	.LIMIT_3A(LIMIT_3A), .ALERT_REQ(ALERT_REQ),
	.OUTPUT_OVERVOLTAGE_FAULT(OUTPUT_OVERVOLTAGE_FAULT),
	.OUTPUT_UNDERVOLTAGE_FAULT(OUTPUT_UNDERVOLTAGE_FAULT),
	.OUTPUT_OVERCURRENT_FAULT(OUTPUT_OVERCURRENT_FAULT),
	.EXT_OVERTEMP_FAULT(EXT_OVERTEMP_FAULT), .STATUS_VOLT(STATUS_VOLT));
`default_nettype wire
